// >>> common/vgr_pkg.sv
package vgr_pkg;

    // Register map, 16-bit register addresses
    localparam logic [15:0] ADDR_FIRST_STATUS = 16'hE502;
    localparam logic [15:0] ADDR_FIRST_MASK   = 16'hE50A;
    localparam logic [15:0] ADDR_CONFIG       = 16'hE618;
    localparam logic [15:0] ADDR_GAIN_BASE    = 16'h4380;
    localparam logic [15:0] ADDR_SAMPLE_BASE  = 16'hE400;

    // Field positions
    localparam int READY_BIT      = 17;
    localparam int FILTER_EN_BIT  = 4;
    localparam int PIN_FN_LSB     = 0;
    localparam int ROUTE_A_LSB    = 8;
    localparam int ROUTE_B_LSB    = 10;
    localparam int ROUTE_C_LSB    = 12;

    // Reset values
    localparam logic [15:0] CONFIG_RESET = 16'h0010;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam logic [1:0]  PIN_FN_READY = 2'h0;

    // Routing codes
    localparam logic [1:0] ROUTE_NEXT = 2'h1;
    localparam logic [1:0] ROUTE_PREV = 2'h2;

    // Channel indices: A, A aux, B, B aux, C, C aux, N, N aux
    localparam int NUM_CHAN = 8;
    localparam int CH_A     = 0;
    localparam int CH_B     = 2;
    localparam int CH_C     = 4;

    // Arithmetic
    localparam int GAIN_FRAC  = 23;
    localparam int DC_FRAC    = 8;
    localparam int HPF_SHIFT  = 10;

    // Timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int PIN_DELAY_NS   = 70;
    localparam int PIN_LOW_US     = 10;
    localparam int PIN_DELAY_CYC  = (PIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_LOW_CYC    = (PIN_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_CNT_W      = 9;

    // Buffer
    localparam int BUF_DEPTH = 2;

    typedef logic signed [23:0] vgr_sample_t;

    typedef struct packed {
        logic [NUM_CHAN-1:0][23:0] volt;
        logic [2:0][23:0]          cur;
    } vgr_adc_t;

    typedef struct packed {
        logic signed [23:0] volt_a;
        logic signed [23:0] cur_a;
        logic signed [23:0] volt_b;
        logic signed [23:0] cur_b;
        logic signed [23:0] volt_c;
        logic signed [23:0] cur_c;
    } vgr_route_t;

    localparam int ROUTE_W = $bits(vgr_route_t);

    typedef enum logic [1:0] {
        PIN_IDLE  = 2'h0,
        PIN_DELAY = 2'h1,
        PIN_LOW   = 2'h3
    } vgr_pin_state_t;

endpackage : vgr_pkg

// >>> rtl/vgr_buf2.sv
`timescale 1ns/1ps
module vgr_buf2
    import vgr_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Fill side
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire vgr_route_t         in_data,
    // Drain side
    output logic                    out_valid,
    input  wire logic               out_ready,
    output vgr_route_t              out_data
);
    import vgr_pkg::*;

    vgr_route_t     store [BUF_DEPTH];
    logic           rd_idx;
    logic           wr_idx;
    logic [1:0]     count;
    wire            push = in_valid & in_ready;
    wire            pop  = out_valid & out_ready;

    assign in_ready  = (count != 2'(BUF_DEPTH));
    assign out_valid = (count != 2'h0);
    assign out_data  = store[rd_idx];

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_idx <= 1'b0;
            wr_idx <= 1'b0;
            count  <= 2'h0;
        end
        else
        begin
            if (push)
                wr_idx <= ~wr_idx;
            if (pop)
                rd_idx <= ~rd_idx;
            count <= count + 2'(push) - 2'(pop);
        end
    end

    // Storage needs no reset; valid is governed by count
    always_ff @(posedge sys_clk)
    begin
        if (push)
            store[wr_idx] <= in_data;
    end

endmodule : vgr_buf2

// >>> rtl/vgr_core.sv
`timescale 1ns/1ps
// Operation
// - Voltage scaled by one plus gain/2^23
// - 0x400000 adds half, 0xC00000 removes half
// - Gained voltage feeds all downstream paths
// - Gain reads sign-extended, four zero LSBs
// - Filter enable bit 4, resets one
// - Enabled highpass removes constant voltage offset
// - Capture filtered voltages, eight 24-bit registers
// - Ready flag bit 17 on new samples
// - Mask bit 17 enables interrupt
// - Pin low 70ns after flag, 10us
// - Sample reads sign-extended to 32 bits
// - Bits 9:8 pick phase A voltage
// - Bits 11:10 pick phase B voltage
// - Bits 13:12 pick phase C voltage
// - Own current paired with routed voltage
// - Flag and interrupt held until write-one
// - Event pin pulses low per computation cycle
module vgr_core
    import vgr_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // ADC sample stream, one set per 8 kHz cycle
    input  wire logic               adc_valid,
    output logic                    adc_ready,
    input  wire vgr_pkg::vgr_adc_t  adc_data,
    // Register port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [15:0]        reg_addr,
    input  wire logic [31:0]        reg_wdata,
    output logic [31:0]             reg_rdata,
    output logic                    reg_rd_valid,
    // Power datapath
    output logic                    pwr_valid,
    input  wire logic               pwr_ready,
    output vgr_pkg::vgr_route_t     pwr_data,
    // Pins
    output logic                    first_interrupt_request_pin_n,
    output logic                    shared_event_pin_n,
    output logic                    shared_event_pin_oe
);
    import vgr_pkg::*;

    function automatic vgr_sample_t vgr_sat24(input logic signed [33:0] v);
        if (v > 34'sh0_007F_FFFF)
            return 24'sh7F_FFFF;
        else if (v < -34'sh0_0080_0000)
            return 24'sh80_0000;
        else
            return v[23:0];
    endfunction : vgr_sat24

    function automatic vgr_sample_t vgr_gain(input vgr_sample_t x, input vgr_sample_t g);
        logic signed [47:0] prod;
        prod = x * g;
        return vgr_sat24(34'(x) + 34'(prod >>> GAIN_FRAC));
    endfunction : vgr_gain

    function automatic vgr_sample_t vgr_hpf_out(input vgr_sample_t x,
                                                input logic signed [31:0] dc);
        return vgr_sat24(34'(x) - 34'(dc >>> DC_FRAC));
    endfunction : vgr_hpf_out

    function automatic logic signed [31:0] vgr_hpf_next(input vgr_sample_t x,
                                                        input logic signed [31:0] dc);
        logic signed [31:0] err;
        err = (32'(x) <<< DC_FRAC) - dc;
        return dc + (err >>> HPF_SHIFT);
    endfunction : vgr_hpf_next

    function automatic vgr_sample_t vgr_route(input logic [1:0] sel, input vgr_sample_t own,
                                              input vgr_sample_t nxt, input vgr_sample_t prv);
        if (sel == ROUTE_NEXT)
            return nxt;
        else if (sel == ROUTE_PREV)
            return prv;
        else
            return own;
    endfunction : vgr_route

    function automatic logic [31:0] vgr_sext32(input vgr_sample_t v);
        return {{8{v[23]}}, v};
    endfunction : vgr_sext32

    // Register state
    vgr_sample_t            gain      [NUM_CHAN];
    vgr_sample_t            sample    [NUM_CHAN];
    logic signed [31:0]     dc_est    [NUM_CHAN];
    logic [31:0]            mask;
    logic [15:0]            config_q;
    logic                   sample_ready_flag;
    logic                   ready_set;

    // Pin sequencer
    vgr_pin_state_t         pin_state;
    vgr_pin_state_t         next_pin_state;
    logic [PIN_CNT_W-1:0]   pin_cnt;
    logic [PIN_CNT_W-1:0]   next_pin_cnt;

    // Decode
    wire        filter_enable       = config_q[FILTER_EN_BIT];
    wire [1:0]  shared_pin_function = config_q[PIN_FN_LSB +: 2];
    wire [1:0]  route_into_phase_a  = config_q[ROUTE_A_LSB +: 2];
    wire [1:0]  route_into_phase_b  = config_q[ROUTE_B_LSB +: 2];
    wire [1:0]  route_into_phase_c  = config_q[ROUTE_C_LSB +: 2];
    wire        hit_status = (reg_addr == ADDR_FIRST_STATUS);
    wire        hit_mask   = (reg_addr == ADDR_FIRST_MASK);
    wire        hit_config = (reg_addr == ADDR_CONFIG);
    wire        hit_gain   = (reg_addr[15:3] == ADDR_GAIN_BASE[15:3]);
    wire        hit_sample = (reg_addr[15:3] == ADDR_SAMPLE_BASE[15:3]);
    wire [2:0]  reg_idx    = reg_addr[2:0];
    wire        take       = adc_valid & adc_ready;
    wire        ready_clr  = reg_wr & hit_status & reg_wdata[READY_BIT];

    // Per-channel processing
    vgr_sample_t            gained    [NUM_CHAN];
    vgr_sample_t            filtered  [NUM_CHAN];
    logic signed [31:0]     next_dc   [NUM_CHAN];

    for (genvar c = 0; c < NUM_CHAN; c++)
    begin : g_chan
        assign gained[c]   = vgr_gain(adc_data.volt[c], gain[c]);
        assign filtered[c] = filter_enable ? vgr_hpf_out(gained[c], dc_est[c])
                                           : gained[c];
        assign next_dc[c]  = vgr_hpf_next(gained[c], dc_est[c]);
    end

    // Routed voltages with each phase's own current
    vgr_route_t route_bus;
    assign route_bus.volt_a = vgr_route(route_into_phase_a, filtered[CH_A],
                                        filtered[CH_B], filtered[CH_C]);
    assign route_bus.volt_b = vgr_route(route_into_phase_b, filtered[CH_B],
                                        filtered[CH_C], filtered[CH_A]);
    assign route_bus.volt_c = vgr_route(route_into_phase_c, filtered[CH_C],
                                        filtered[CH_A], filtered[CH_B]);
    assign route_bus.cur_a  = adc_data.cur[0];
    assign route_bus.cur_b  = adc_data.cur[1];
    assign route_bus.cur_c  = adc_data.cur[2];

    // Full buffer stalls the ADC stream, so no sample set is dropped
    vgr_buf2 u_buf (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (adc_valid),
        .in_ready  (adc_ready),
        .in_data   (route_bus),
        .out_valid (pwr_valid),
        .out_ready (pwr_ready),
        .out_data  (pwr_data)
    );

    // Sample capture and filter state
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int c = 0; c < NUM_CHAN; c++)
            begin
                sample[c] <= 24'sh00_0000;
                dc_est[c] <= 32'sh0000_0000;
            end
        end
        else if (take)
        begin
            for (int c = 0; c < NUM_CHAN; c++)
            begin
                sample[c] <= filtered[c];
                if (filter_enable)
                    dc_est[c] <= next_dc[c];
            end
        end
    end

    // Flag trails the sample update by one edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_set         <= 1'b0;
            sample_ready_flag <= 1'b0;
        end
        else
        begin
            ready_set         <= take;
            sample_ready_flag <= ready_set | (sample_ready_flag & ~ready_clr);
        end
    end

    // Writable registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask     <= MASK_RESET;
            config_q <= CONFIG_RESET;
            for (int c = 0; c < NUM_CHAN; c++)
                gain[c] <= 24'sh00_0000;
        end
        else if (reg_wr)
        begin
            if (hit_mask)
                mask <= reg_wdata;
            if (hit_config)
                config_q <= reg_wdata[15:0];
            // Gain is written as it reads: 24-bit value above four pad bits
            if (hit_gain)
                gain[reg_idx] <= reg_wdata[27:4];
        end
    end

    // Read mux
    logic [31:0] read_mux;
    assign read_mux =
        hit_status ? (32'(sample_ready_flag) << READY_BIT) :
        hit_mask   ? mask :
        hit_config ? {16'h0000, config_q} :
        hit_gain   ? {{4{gain[reg_idx][23]}}, gain[reg_idx], 4'h0} :
        hit_sample ? vgr_sext32(sample[reg_idx]) :
                     32'h0000_0000;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata    <= 32'h0000_0000;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd;
            if (reg_rd)
                reg_rdata <= read_mux;
        end
    end

    // Interrupt follows the sticky flag, so it stays low until cleared
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            first_interrupt_request_pin_n <= 1'b1;
        else
            first_interrupt_request_pin_n <=
                ~(mask[READY_BIT] & (ready_set | (sample_ready_flag & ~ready_clr)));
    end

    // Pulse sequencer; a new flag during a pulse is not restarted,
    // the sample period far exceeds the pulse
    always_comb
    begin
        next_pin_state = pin_state;
        next_pin_cnt   = pin_cnt;
        unique case (pin_state)
            PIN_IDLE:
            begin
                if (ready_set && shared_pin_function == PIN_FN_READY)
                begin
                    next_pin_state = PIN_DELAY;
                    next_pin_cnt   = PIN_CNT_W'(PIN_DELAY_CYC - 1);
                end
            end
            PIN_DELAY:
            begin
                if (pin_cnt == '0)
                begin
                    next_pin_state = PIN_LOW;
                    next_pin_cnt   = PIN_CNT_W'(PIN_LOW_CYC - 1);
                end
                else
                    next_pin_cnt = pin_cnt - 1'b1;
            end
            PIN_LOW:
            begin
                if (pin_cnt == '0)
                    next_pin_state = PIN_IDLE;
                else
                    next_pin_cnt = pin_cnt - 1'b1;
            end
            default:
            begin
                next_pin_state = PIN_IDLE;
                next_pin_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_state          <= PIN_IDLE;
            pin_cnt            <= '0;
            shared_event_pin_n <= 1'b1;
        end
        else
        begin
            pin_state          <= next_pin_state;
            pin_cnt            <= next_pin_cnt;
            shared_event_pin_n <= (next_pin_state != PIN_LOW);
        end
    end

    // Other pin functions are outside this block; pin idles high
    assign shared_event_pin_oe = 1'b1;

endmodule : vgr_core

// >>> test/vgr_core_assertions.sv
`timescale 1ns/1ps
module vgr_core_chk
    import vgr_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Streams
    input  wire logic                adc_valid,
    input  wire logic                adc_ready,
    input  wire logic                pwr_valid,
    input  wire logic                pwr_ready,
    input  wire vgr_pkg::vgr_route_t pwr_data,
    // Register port
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [15:0]         reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic [31:0]         reg_rdata,
    input  wire logic                reg_rd_valid,
    // Pins
    input  wire logic                first_interrupt_request_pin_n,
    input  wire logic                shared_event_pin_n,
    input  wire logic                shared_event_pin_oe
);
    logic       acc;
    logic [8:0] low_cnt;
    assign acc = adc_valid && adc_ready;
    // Length of the current low stretch of the event pin
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            low_cnt <= 9'h000;
        else
            low_cnt <= shared_event_pin_n ? 9'h000 : low_cnt + 9'h001;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_pin_driven: assert property (shared_event_pin_oe)
        else $error("event pin not driven");
    a_read_answer: assert property (reg_rd |=> reg_rd_valid)
        else $error("read not answered next cycle");
    a_read_hold: assert property (!reg_rd |=> !reg_rd_valid && $stable(reg_rdata))
        else $error("read data moved without a read");
    a_irq_cause: assert property ($fell(first_interrupt_request_pin_n) |->
        $past(acc, 1) || $past(acc, 2) || $past(reg_wr, 1) || $past(reg_wr, 2))
        else $error("interrupt fell without a sample set or write");
    a_irq_clear: assert property (reg_wr && reg_addr == ADDR_FIRST_STATUS
        && reg_wdata[READY_BIT] && !acc && !$past(acc) |-> ##[1:2] first_interrupt_request_pin_n)
        else $error("interrupt not released by clear");
    a_event_len: assert property ($rose(shared_event_pin_n) |-> low_cnt == 9'h190)
        else $error("event pulse length wrong");
    a_event_cause: assert property ($fell(shared_event_pin_n) |->
        $past(acc, 3) || $past(acc, 4) || $past(acc, 5) || $past(acc, 6))
        else $error("event pulse without a fresh sample set");
    a_pwr_hold: assert property (pwr_valid && !pwr_ready |=> pwr_valid && $stable(pwr_data))
        else $error("power word dropped while stalled");
    a_pwr_fill: assert property (acc |=> pwr_valid)
        else $error("accepted set gave no power word");
    c_irq: cover property ($fell(first_interrupt_request_pin_n));
    c_event: cover property ($rose(shared_event_pin_n));
    c_full: cover property (adc_valid && !adc_ready);
endmodule : vgr_core_chk

bind vgr_core vgr_core_chk u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .pwr_valid(pwr_valid), .pwr_ready(pwr_ready), .pwr_data(pwr_data), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .first_interrupt_request_pin_n(first_interrupt_request_pin_n),
    .shared_event_pin_n(shared_event_pin_n), .shared_event_pin_oe(shared_event_pin_oe)
);

// >>> test/vgr_pwr_sink.sv
`timescale 1ns/1ps
module vgr_pwr_sink
    import vgr_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Bench control
    input  wire logic                stall,
    // Power datapath
    input  wire logic                pwr_valid,
    output logic                     pwr_ready,
    input  wire vgr_pkg::vgr_route_t pwr_data
);
    int taken;
    // Stalls only on command, so held words can be inspected
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_ready <= 1'b0;
            taken     <= 0;
        end
        else
        begin
            pwr_ready <= !stall;
            if (pwr_valid && pwr_ready)
                taken <= taken + 1;
        end
    end
endmodule : vgr_pwr_sink

// >>> test/tb_vgr_core.sv
`timescale 1ns/1ps
module tb_vgr_core;
    import vgr_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        adc_valid = 1'b0;
    vgr_adc_t    adc_data = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        stall = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic        adc_ready, reg_rd_valid, pwr_valid, pwr_ready, irq_n, evt_n, evt_oe;
    vgr_route_t  pwr_data;
    int          failures = 0;
    int          checked = 0;
    int          lo, e;

    always #12.5 sys_clk = ~sys_clk;

    vgr_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .adc_valid(adc_valid),
        .adc_ready(adc_ready), .adc_data(adc_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .pwr_valid(pwr_valid), .pwr_ready(pwr_ready),
        .pwr_data(pwr_data), .first_interrupt_request_pin_n(irq_n),
        .shared_event_pin_n(evt_n), .shared_event_pin_oe(evt_oe));
    vgr_pwr_sink u_sink (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
        .pwr_valid(pwr_valid), .pwr_ready(pwr_ready), .pwr_data(pwr_data));

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read valid", {31'h0, reg_rd_valid}, 32'h1);
        d = reg_rdata;
    endtask : rd

    task send(input vgr_adc_t d);
        @(posedge sys_clk);
        adc_data <= d;
        adc_valid <= 1'b1;
        lo = 0;
        @(negedge sys_clk);
        while (adc_ready !== 1'b1 && lo < 1000)
        begin
            @(negedge sys_clk);
            lo++;
        end
        if (lo >= 1000)
            chk("adc accept", 32'h0, 32'h1);
        @(posedge sys_clk);
        adc_valid <= 1'b0;
    endtask : send

    function automatic vgr_adc_t mk(input logic [23:0] va, vb, vc);
        vgr_adc_t s;
        s.volt = {va, va, vc, vc, vb, vb, va, va};
        s.cur = {24'h0000C1, 24'h0000B1, 24'h0000A1};
        return s;
    endfunction : mk

    function automatic logic [31:0] src(input int p, input int c);
        return 32'(((c == 1) ? (p + 1) % 3 : (c == 2) ? (p + 2) % 3 : p) + 1) << 8;
    endfunction : src

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(ADDR_CONFIG, rv);
        chk("config reset", rv, 32'h0000_0010);
        rd(ADDR_FIRST_MASK, rv);
        chk("mask reset", rv, 32'h0000_0000);
        rd(16'h1234, rv);
        chk("unmapped read", rv, 32'h0000_0000);
        $display("test reset done");
        // Filter on from reset: a constant input must decay away
        for (int i = 0; i < 6000; i++)
            send(mk(24'h001000, 24'h001000, 24'h001000));
        rd(ADDR_SAMPLE_BASE, rv);
        chk("offset removed", {31'h0, $signed(rv) < 64 && $signed(rv) > -64}, 32'h1);
        $display("test highpass done");
        wr(ADDR_CONFIG, 32'h0000_0000);
        repeat (500) @(posedge sys_clk);
        wr(ADDR_FIRST_STATUS, 32'h0002_0000);
        rd(ADDR_FIRST_STATUS, rv);
        chk("flag cleared", rv, 32'h0000_0000);
        send(mk(24'h000100, 24'h000200, 24'h000300));
        repeat (3) @(negedge sys_clk);
        chk("irq masked", {31'h0, irq_n}, 32'h1);
        rd(ADDR_FIRST_STATUS, rv);
        chk("flag set", rv, 32'h0002_0000);
        wr(ADDR_FIRST_MASK, 32'h0002_0000);
        wr(ADDR_FIRST_STATUS, 32'h0002_0000);
        repeat (500) @(posedge sys_clk);
        send(mk(24'h000100, 24'h000200, 24'h000300));
        repeat (3) @(negedge sys_clk);
        chk("irq low", {31'h0, irq_n}, 32'h0);
        lo = 0;
        while (evt_n !== 1'b0 && lo < 20)
        begin
            @(negedge sys_clk);
            lo++;
        end
        lo = 0;
        while (evt_n === 1'b0 && lo < 1000)
        begin
            lo++;
            @(negedge sys_clk);
        end
        chk("event low cycles", 32'(lo), 32'h0000_0190);
        chk("irq still low", {31'h0, irq_n}, 32'h0);
        // Host starts its burst read on the rising edge of the event pin
        rd(ADDR_SAMPLE_BASE + 16'h0004, rv);
        chk("burst read c", rv, 32'h0000_0300);
        wr(ADDR_FIRST_STATUS, 32'h0002_0000);
        repeat (2) @(negedge sys_clk);
        chk("irq released", {31'h0, irq_n}, 32'h1);
        $display("test ready flag done");
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CONFIG, (32'(c) << 8) | (32'(c) << 10) | (32'(c) << 12));
            stall <= 1'b1;
            send(mk(24'h000100, 24'h000200, 24'h000300));
            @(negedge sys_clk);
            chk("route a", {8'h00, pwr_data.volt_a}, src(0, c));
            chk("route b", {8'h00, pwr_data.volt_b}, src(1, c));
            chk("route c", {8'h00, pwr_data.volt_c}, src(2, c));
            chk("own current a", {8'h00, pwr_data.cur_a}, 32'h0000_00A1);
            chk("own current", {8'h00, pwr_data.cur_b}, 32'h0000_00B1);
            chk("own current c", {8'h00, pwr_data.cur_c}, 32'h0000_00C1);
            stall <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        $display("test routing done");
        wr(ADDR_CONFIG, 32'h0000_0000);
        wr(ADDR_GAIN_BASE, 32'h0400_0000);
        wr(ADDR_GAIN_BASE + 16'h0002, 32'h0C00_0000);
        rd(ADDR_GAIN_BASE, rv);
        chk("gain a", rv, 32'h0400_0000);
        rd(ADDR_GAIN_BASE + 16'h0002, rv);
        chk("gain b", rv, 32'hFC00_0000);
        for (int k = 0; k < 2; k++)
        begin
            e = $signed(k == 0 ? 24'h001000 : 24'hFFF000);
            stall <= 1'b1;
            send(mk(24'(e), 24'(e), 24'(e)));
            @(negedge sys_clk);
            chk("gained power", 32'($signed(pwr_data.volt_a)), 32'(e + e / 2));
            for (int ch = 0; ch < NUM_CHAN; ch++)
            begin
                rd(ADDR_SAMPLE_BASE + 16'(ch), rv);
                chk("sample", rv, 32'(ch == 0 ? e + e / 2 : ch == 2 ? e - e / 2 : e));
            end
            stall <= 1'b0;
            // Drain the held word so the next set is the one at the head
            repeat (4) @(posedge sys_clk);
        end
        wr(ADDR_SAMPLE_BASE, 32'h0000_0005);
        rd(ADDR_SAMPLE_BASE, rv);
        chk("sample read only", rv, 32'hFFFF_E800);
        $display("test gain done");
        stall <= 1'b1;
        send(mk(24'h000100, 24'h000200, 24'h000300));
        send(mk(24'h000100, 24'h000200, 24'h000300));
        @(negedge sys_clk);
        chk("buffer full", {31'h0, adc_ready}, 32'h0);
        stall <= 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("buffer drained", {31'h0, pwr_valid}, 32'h0);
        // One power word per accepted sample set, 6010 sets sent
        chk("words taken", 32'(u_sink.taken), 32'h0000_177A);
        $display("test buffer done");
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        tally_and_finish();
    end
endmodule : tb_vgr_core
